// File: hw/pll_reset_init_sequencer.sv
/*
 register side of the pll reset and initialization control: direct registers,
 indirect page access and the two pll state machine holds.
 assumes a decoded register write/read port from the control bus slave and
 power_en_i as the active-high enable pin, used unsynchronised as an asynchronous reset.
*/
`timescale 1ns/1ps
`include "pll_init_defs.svh"
// Contract
// [R1] hdmi pll bit4 holds its fsm
// [R2] link pll bit4 holds its fsm
// [R3] host writes zero low bits; high reserved
// [R4] freq bit5 clear stops link pll reset
// [R5] register 0x16 sets glitch filter length
// [R6] bit4 of 0x04 blocks blanking video
// [R7] host starts B after tmds stable
// [R8] host resets hdmi pll via page
// [R9] host then resets link pll
// [R10] enable pin after supplies, hdmi after
// [R11] microcontroller drives enable pin
// [R12] inputs idle until supplies steady
// [R13] 0x40 page, 0x41 offset, 0x42 data
// [R14] host waits 2 ms before access
// [R15] tmds stable 1 us before resets
// [R16] hard reset needs 2 ms low
// [R17] host finishes A before B
module pll_reset_init_sequencer
   import pll_init_pkg::*;
#(
   parameter int unsigned RDY_CYCLES = `RDY_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic power_en_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire byte_t reg_addr_i,
   input wire byte_t reg_wdata_i,
   input wire logic freq_change_i,
   output byte_t reg_rdata_o,
   output logic reg_ack_o,
   output logic access_ready_o,
   output logic hdmi_pll_fsm_hold_o,
   output logic link_pll_fsm_hold_o,
   output logic link_pll_freq_reset_o,
   output logic blank_video_block_o,
   output logic [7:0] i2c_filter_o
);
   logic rst_s1_q;
   logic rst_s2_q;
   logic arst_b;
   logic pwr_on;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign pwr_on = rst_s2_q & power_en_i;

   // the enable pin low acts as a full device reset
   assign arst_b = pwr_on;

   function automatic logic hit(input byte_t a, input byte_t b, input logic s);
      hit = s && (a == b);
   endfunction : hit

   pwr_state_e st_q;
   pwr_state_e st_d;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   byte_t page_q;
   byte_t page_d;
   byte_t ofs_q;
   byte_t ofs_d;
   byte_t blank_q;
   byte_t blank_d;
   byte_t filt_q;
   byte_t filt_d;
   byte_t freq_q;
   byte_t freq_d;
   byte_t rdata_q;
   byte_t rdata_d;
   logic ack_q;
   logic ack_d;
   logic rdy_q;
   logic rdy_d;
   logic hh_q;
   logic lh_q;
   logic lf_q;
   logic lf_d;
   logic bv_q;
   byte_t filt_o_q;
   logic wr_ok;
   logic rd_ok;
   logic wr_hdmi;
   logic wr_link;
   logic hdmi_hold;
   logic link_hold;
   byte_t hdmi_rd;
   byte_t link_rd;

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      rdy_d = 1'b0;
      case (st_q)
         ST_DOWN:
         begin
            cnt_d = 32'h0;
            st_d = ST_WAKE;
         end
         ST_WAKE:
         begin
            cnt_d = cnt_q + 32'h1;
            if (cnt_q >= RDY_CYCLES - 1) // R14
            begin
               st_d = ST_READY;
            end
         end
         ST_READY:
         begin
            rdy_d = 1'b1;
         end
         default:
         begin
            st_d = ST_DOWN;
         end
      endcase
   end

   assign wr_ok = reg_wr_i && (st_q == ST_READY);
   assign rd_ok = reg_rd_i && (st_q == ST_READY);
   assign wr_hdmi = hit(reg_addr_i, `PAGE_DAT_ADDR, wr_ok) && page_q == `PAGE_HDMI_PLL &&
      ofs_q == `FSM_CTRL_OFS; // R13
   assign wr_link = hit(reg_addr_i, `PAGE_DAT_ADDR, wr_ok) && page_q == `PAGE_LINK_PLL &&
      ofs_q == `FSM_CTRL_OFS; // R13

   always_comb
   begin
      page_d = page_q;
      ofs_d = ofs_q;
      blank_d = blank_q;
      filt_d = filt_q;
      freq_d = freq_q;
      ack_d = reg_wr_i | reg_rd_i;
      rdata_d = rdata_q;
      if (hit(reg_addr_i, `PAGE_SEL_ADDR, wr_ok))
      begin
         page_d = reg_wdata_i; // R13
      end
      if (hit(reg_addr_i, `PAGE_OFS_ADDR, wr_ok))
      begin
         ofs_d = reg_wdata_i; // R13
      end
      if (hit(reg_addr_i, `BLANK_CTRL_ADDR, wr_ok))
      begin
         blank_d = reg_wdata_i;
      end
      if (hit(reg_addr_i, `I2C_FILT_ADDR, wr_ok))
      begin
         filt_d = reg_wdata_i;
      end
      if (hit(reg_addr_i, `FREQ_MON_ADDR, wr_ok))
      begin
         freq_d = reg_wdata_i;
      end
      if (rd_ok)
      begin
         case (reg_addr_i)
            `PAGE_SEL_ADDR: rdata_d = page_q;
            `PAGE_OFS_ADDR: rdata_d = ofs_q;
            `PAGE_DAT_ADDR: rdata_d = (page_q == `PAGE_HDMI_PLL && ofs_q == `FSM_CTRL_OFS) ? hdmi_rd :
               (page_q == `PAGE_LINK_PLL && ofs_q == `FSM_CTRL_OFS) ? link_rd : 8'h00;
            `BLANK_CTRL_ADDR: rdata_d = blank_q;
            `I2C_FILT_ADDR: rdata_d = filt_q;
            `FREQ_MON_ADDR: rdata_d = freq_q;
            default: rdata_d = 8'h00;
         endcase
      end
      else if (reg_rd_i)
      begin
         rdata_d = 8'h00;
      end
      // link pll reset on frequency change only while enabled
      lf_d = freq_change_i & freq_q[`FREQ_RST_BIT]; // R4
   end

   fsm_hold_reg u_hdmi_hold
   (
      .clk_i(clk_i),
      .rst_b_i(arst_b),
      .wr_i(wr_hdmi),
      .wdata_i(reg_wdata_i),
      .hold_o(hdmi_hold),
      .rdata_o(hdmi_rd)
   );

   fsm_hold_reg u_link_hold
   (
      .clk_i(clk_i),
      .rst_b_i(arst_b),
      .wr_i(wr_link),
      .wdata_i(reg_wdata_i),
      .hold_o(link_hold),
      .rdata_o(link_rd)
   );

   always_ff @(posedge clk_i or negedge arst_b)
   begin
      if (!arst_b)
      begin
         st_q <= ST_DOWN;
         cnt_q <= 32'h0;
         rdy_q <= 1'b0;
         page_q <= 8'h00;
         ofs_q <= 8'h00;
         blank_q <= `BLANK_CTRL_RST;
         filt_q <= `I2C_FILT_RST;
         freq_q <= `FREQ_MON_RST;
         rdata_q <= 8'h00;
         ack_q <= 1'b0;
         hh_q <= 1'b0;
         lh_q <= 1'b0;
         lf_q <= 1'b0;
         bv_q <= 1'b0;
         filt_o_q <= 8'h00;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
         page_q <= page_d;
         ofs_q <= ofs_d;
         blank_q <= blank_d;
         filt_q <= filt_d;
         freq_q <= freq_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         hh_q <= hdmi_hold; // R1
         lh_q <= link_hold; // R2
         lf_q <= lf_d; // R4
         bv_q <= blank_q[`BLANK_SUPP_BIT]; // R6
         filt_o_q <= filt_q; // R5
      end
   end

   assign reg_rdata_o = rdata_q;
   assign reg_ack_o = ack_q;
   assign access_ready_o = rdy_q;
   assign hdmi_pll_fsm_hold_o = hh_q;
   assign link_pll_fsm_hold_o = lh_q;
   assign link_pll_freq_reset_o = lf_q;
   assign blank_video_block_o = bv_q;
   assign i2c_filter_o = filt_o_q;

   hdmi_hold_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R1
      wr_hdmi |=> ##1 hdmi_pll_fsm_hold_o == $past(reg_wdata_i[`FSM_HOLD_BIT], 2))
      else $error("hdmi hold mismatch");
   link_hold_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R2
      wr_link |=> ##1 link_pll_fsm_hold_o == $past(reg_wdata_i[`FSM_HOLD_BIT], 2))
      else $error("link hold mismatch");
   resv_zero_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R3
      (hdmi_rd[7:5] == 3'h0) && (hdmi_rd[3:0] == 4'h0) && (link_rd[7:5] == 3'h0) && (link_rd[3:0] == 4'h0))
      else $error("reserved bits not zero");
   freq_gate_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R4
      !freq_q[`FREQ_RST_BIT] |=> !link_pll_freq_reset_o)
      else $error("freq reset while disabled");
   filt_out_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R5
      hit(reg_addr_i, `I2C_FILT_ADDR, wr_ok) |=> ##1 i2c_filter_o == $past(reg_wdata_i, 2))
      else $error("filter value wrong");
   blank_out_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R6
      hit(reg_addr_i, `BLANK_CTRL_ADDR, wr_ok) |=> ##1 blank_video_block_o == $past(reg_wdata_i[`BLANK_SUPP_BIT], 2))
      else $error("blank control wrong");
   page_sel_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R13
      hit(reg_addr_i, `PAGE_SEL_ADDR, wr_ok) |=> page_q == $past(reg_wdata_i))
      else $error("page select not stored");
   wake_gate_a: assert property (@(posedge clk_i) disable iff (!arst_b) // R14
      access_ready_o |-> cnt_q >= RDY_CYCLES - 1)
      else $error("ready too early");
   cov_hdmi_c: cover property (@(posedge clk_i) disable iff (!arst_b) wr_hdmi ##[1:20] wr_link);
   cov_ready_c: cover property (@(posedge clk_i) disable iff (!arst_b) $rose(access_ready_o));
   cov_blank_c: cover property (@(posedge clk_i) disable iff (!arst_b) $rose(blank_video_block_o));
endmodule : pll_reset_init_sequencer

// File: hw/pll_init_defs.svh
/*
 register map constants for the pll reset and init sequencer.
 assumes the includer wants plain `define values.
*/
`ifndef PLL_INIT_DEFS_SVH
`define PLL_INIT_DEFS_SVH
`define PAGE_SEL_ADDR 8'h40
`define PAGE_OFS_ADDR 8'h41
`define PAGE_DAT_ADDR 8'h42
`define BLANK_CTRL_ADDR 8'h04
`define I2C_FILT_ADDR 8'h16
`define FREQ_MON_ADDR 8'h5B
`define PAGE_HDMI_PLL 8'h10
`define PAGE_LINK_PLL 8'h14
`define FSM_CTRL_OFS 8'h49
`define FSM_HOLD_BIT 4
`define BLANK_SUPP_BIT 4
`define FREQ_RST_BIT 5
`define FSM_CTRL_RST 8'h00
`define BLANK_CTRL_RST 8'h00
`define I2C_FILT_RST 8'h00
`define FREQ_MON_RST 8'h20
`define FSM_CTRL_MASK 8'h10
`define RDY_TIME_MS 2
`define CLK_HZ 10000000
`define RDY_CYCLES ((`RDY_TIME_MS * `CLK_HZ) / 1000)
`endif

// File: hw/pll_init_pkg.sv
/*
 types shared by the sequencer files.
 assumes pll_init_defs.svh supplies the numbers.
*/
package pll_init_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {ST_DOWN, ST_WAKE, ST_READY} pwr_state_e;
endpackage : pll_init_pkg

// File: hw/fsm_hold_reg.sv
/*
 one paged pll state machine control register, only the hold bit stored.
 assumes a decoded write strobe and data from the indirect access port.
*/
`timescale 1ns/1ps
`include "pll_init_defs.svh"
module fsm_hold_reg
   import pll_init_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic wr_i,
   input wire byte_t wdata_i,
   output logic hold_o,
   output byte_t rdata_o
);
   logic hold_q;
   logic hold_d;

   always_comb
   begin
      hold_d = hold_q;
      if (wr_i)
      begin
         hold_d = wdata_i[`FSM_HOLD_BIT]; // R1 R2
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         hold_q <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
      end
   end

   assign hold_o = hold_q;
   // reserved bits read as zero
   assign rdata_o = {3'h0, hold_q, 4'h0}; // R3
endmodule : fsm_hold_reg

// File: test/host_model.sv
/*
 host controller model: issues single register writes and reads.
 assumes the block answers each strobe with one ack pulse a cycle later.
*/
`timescale 1ns/1ps
module host_model
   import pll_init_pkg::*;
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire byte_t rdata_i,
   output logic wr_o,
   output logic rd_o,
   output byte_t addr_o,
   output byte_t wdata_o
);
   bit hang = 0;
   initial
   begin
      wr_o = 0;
      rd_o = 0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   task automatic xfer(input logic w, input byte_t a, input byte_t d, output byte_t q);
      int n;
      @(negedge clk_i);
      wr_o = w;
      rd_o = !w;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_o = 0;
      rd_o = 0;
      addr_o = ~a;
      wdata_o = ~d;
      n = 0;
      while (ack_i !== 1'b1 && n < 4)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 4)
         hang = 1;
      q = rdata_i;
   endtask : xfer
endmodule : host_model

// File: test/testbench.sv
/*
 self-checking bench for the pll reset and init sequencer.
 assumes host_model drives the register port.
*/
`timescale 1ns/1ps
`include "pll_init_defs.svh"
module testbench
   import pll_init_pkg::*;
();
   localparam int unsigned RDY = 8;
   logic clk_i = 0;
   logic rst_b_i = 0;
   logic power_en_i = 1;
   logic freq_change_i = 0;
   logic wr, rd, ack, rdy, hh, lh, fr, bv;
   byte_t addr, wdata, rdata, filt, q;
   int n_mismatch = 0;
   int n_compared = 0;
   always #50 clk_i = ~clk_i;
   pll_reset_init_sequencer #(.RDY_CYCLES(RDY)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .power_en_i(power_en_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .freq_change_i(freq_change_i), .reg_rdata_o(rdata), .reg_ack_o(ack),
      .access_ready_o(rdy), .hdmi_pll_fsm_hold_o(hh), .link_pll_fsm_hold_o(lh),
      .link_pll_freq_reset_o(fr), .blank_video_block_o(bv), .i2c_filter_o(filt));
   host_model host (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata));
   task automatic print_verdict;
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input byte_t seen, input byte_t exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr1(input byte_t a, input byte_t d);
      host.xfer(1, a, d, q);
   endtask : wr1
   task automatic rd1(input byte_t a, input byte_t e);
      host.xfer(0, a, 8'h00, q);
      chk(q, e);
   endtask : rd1
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : idle
   task automatic wait_ready(input int n0);
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 4 * RDY + 20)
      begin
         @(negedge clk_i);
         n++;
      end
      chk({7'h0, rdy}, 8'h01);
      chk({7'h0, (n + n0) >= RDY}, 8'h01);
      if (rdy !== 1'b1)
         print_verdict();
   endtask : wait_ready
   task automatic pulse(input logic e);
      logic s;
      s = 0;
      freq_change_i = 1;
      repeat (5)
      begin
         @(negedge clk_i);
         freq_change_i = 0;
         s |= fr;
      end
      chk({7'h0, s}, {7'h0, e});
   endtask : pulse
   task automatic t_init_a;
      pulse(1);
      wr1(`FREQ_MON_ADDR, 8'h00);
      wr1(`I2C_FILT_ADDR, 8'h02);
      wr1(`BLANK_CTRL_ADDR, 8'h10);
      idle(3);
      chk(filt, 8'h02);
      chk({7'h0, bv}, 8'h01);
      rd1(`I2C_FILT_ADDR, 8'h02);
      rd1(`BLANK_CTRL_ADDR, 8'h10);
      pulse(0);
   endtask : t_init_a
   task automatic t_init_b;
      byte_t pg;
      for (int i = 0; i < 2; i++)
      begin
         pg = i ? `PAGE_LINK_PLL : `PAGE_HDMI_PLL;
         wr1(`PAGE_SEL_ADDR, pg);
         wr1(`PAGE_OFS_ADDR, 8'h48);
         wr1(`PAGE_DAT_ADDR, 8'h10);
         idle(3);
         chk({6'h0, hh, lh}, 8'h00);
         rd1(`PAGE_DAT_ADDR, 8'h00);
         wr1(`PAGE_OFS_ADDR, `FSM_CTRL_OFS);
         rd1(`PAGE_SEL_ADDR, pg);
         rd1(`PAGE_OFS_ADDR, `FSM_CTRL_OFS);
         wr1(`PAGE_DAT_ADDR, 8'hF0);
         idle(3);
         chk({6'h0, hh, lh}, i ? 8'h01 : 8'h02);
         rd1(`PAGE_DAT_ADDR, 8'h10);
         wr1(`PAGE_DAT_ADDR, 8'h00);
         idle(3);
         chk({6'h0, hh, lh}, 8'h00);
      end
   endtask : t_init_b
   task automatic t_power;
      power_en_i = 0;
      idle(RDY);
      chk({4'h0, hh, lh, rdy, bv}, 8'h00);
      chk(filt, 8'h00);
      power_en_i = 1;
      wr1(`I2C_FILT_ADDR, 8'h55);
      rd1(`BLANK_CTRL_ADDR, 8'h00);
      chk({7'h0, rdy}, 8'h00);
      wait_ready(4);
      rd1(`I2C_FILT_ADDR, `I2C_FILT_RST);
      rd1(`FREQ_MON_ADDR, `FREQ_MON_RST);
   endtask : t_power
   initial
   begin
      repeat (16) @(negedge clk_i);
      rst_b_i = 1;
      wait_ready(0);
      rd1(`FREQ_MON_ADDR, `FREQ_MON_RST);
      rd1(8'h77, 8'h00);
      t_init_a();
      idle(10);
      t_init_b();
      t_power();
      print_verdict();
   end
   always @(negedge clk_i)
      if (host.hang)
      begin
         n_mismatch++;
         $display("unexpected at %0t: no ack", $time);
         print_verdict();
      end
endmodule : testbench
